// file: hdl/ncs_sequencer.sv
// Charge sequencer: qualification, conditioning, fast charge, maintenance
// Overview of operation
// - Any power-up, pack replacement or sleep exit restarts the cycle.
// - Cycle starts in qualification; a low cell enters conditioning.
// - Conditioning pulses the gate once per second, width set by pin.
// - Lamp blinks at 1 Hz during qualification and conditioning.
// - Conditioning lasts indefinitely; leave when cell good and temperature ok.
// - No charge timer runs while conditioning.
// - Fast charge holds lamp on and watches time, temperature, voltage.
// - After fast charge, optional top-off then trickle while below max.
// - Peak-drop detection disabled for max time over 32 at start.
// - Timer expiry in fast charge goes to top-off or trickle.
// - Timer cleared when fast charge ends if top-off enabled.
// - Cold fault in fast charge freezes timer, conditions with blink, resumes after.
// - Hot fault comparator ignored during fast charge.
// - Cutoff ends fast charge, lamp off, trickle once above hot.
// - Pack voltage continuously kept at or below max threshold.
// - Sample every max time over 128, track peak, flag drop.
// - Gate and timer pin driven low just before each sample.
// - Converter sampling only in fast charge.
// - Gate high lets current flow, low blocks it.
// - Lamp is open-drain: on, off or flashing.
module ncs_sequencer #(
    parameter logic [39:0] MAX_TIME_CYC = 40'd900_000_000_000,
    parameter logic [31:0] PULSE_SHORT_CYC = 32'd15_625_000,
    parameter logic [31:0] PULSE_LONG_CYC = 32'd62_500_000,
    parameter logic [31:0] TOPOFF_PULSE_CYC = 32'd15_625_000,
    parameter logic [31:0] PERIOD_CYCLES = 32'd250_000_000
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic power_applied,
    input wire logic pack_replaced,
    input wire logic sleep_exit,
    input wire logic topoff_enable,
    input wire logic timer_program_in,
    input wire logic below_low_cell,
    input wire logic above_max_cell,
    input wire logic above_cold_fault,
    input wire logic below_hot_fault,
    input wire logic below_cutoff,
    input wire logic [11:0] adc_sample,
    input wire logic adc_valid,
    output logic adc_start,
    output logic charge_gate_output,
    output logic timer_program_out,
    output logic timer_program_oe,
    output logic status_lamp_out,
    output logic status_lamp_oe,
    output logic peak_drop_detect,
    output ncs_pkg::ncs_state_t charge_state
);
    import ncs_pkg::*;
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    logic [7:0] pins_raw, pins;
    assign pins_raw = {power_applied, pack_replaced, sleep_exit,
        timer_program_in, below_low_cell, above_max_cell, above_cold_fault,
        below_hot_fault};
    ncs_sync #(.W(8)) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in(pins_raw),
        .level_out(pins)
    );
    logic cut_s1, cut_s2, cut_s3, cut_q;
    logic pwr, rep, slp, prog, low_cell, max_cell, cold, hot;
    assign {pwr, rep, slp, prog, low_cell, max_cell, cold, hot} = pins;

    logic [2:0] start_q;
    logic [2:0] settle_q;
    wire start_now = |({pwr, rep, slp} & ~start_q);

    ncs_state_t state_q, state_d;
    logic [39:0] timer_q, timer_d;
    logic [31:0] sec_q;
    logic [39:0] samp_cnt_q;
    logic [4:0] quiet_q;
    logic sampling_q;
    logic [11:0] peak_q;
    logic drop_q, have_peak_q, gate_q, lamp_on_q, topoff_sel_q;

    wire [39:0] holdoff_cyc = MAX_TIME_CYC / 40'(HOLDOFF_DIV);
    wire [39:0] sample_cyc = MAX_TIME_CYC / 40'(SAMPLE_DIV);
    wire timer_done = timer_q >= MAX_TIME_CYC;
    wire in_holdoff = timer_q < holdoff_cyc;
    wire good_temp = !cold && !hot;
    wire [31:0] trickle_w = prog ? PULSE_LONG_CYC : PULSE_SHORT_CYC;
    wire fast_end = timer_done || (drop_q && !in_holdoff);
    // Half the frame, so the blink follows a shortened period too
    wire blink_phase = sec_q < (PERIOD_CYCLES >> 1);

    // Next-state selection
    always_comb begin
        state_d = state_q;
        case (state_q)
            NCS_QUAL: begin
                // Comparator levels are not valid while the sync fills
                if (settle_q == 3'h0) begin
                    state_d = (low_cell || !good_temp) ? NCS_COND :
                        NCS_FAST;
                end
            end
            NCS_COND: begin
                if (!low_cell && good_temp) begin
                    state_d = NCS_FAST;
                end
            end
            NCS_FAST: begin
                if (cut_q) begin
                    state_d = NCS_SUSPEND;
                end else if (cold) begin
                    state_d = NCS_COND;
                end else if (fast_end) begin
                    state_d = topoff_sel_q ? NCS_TOPOFF : NCS_TRICKLE;
                end
            end
            NCS_TOPOFF: begin
                if (timer_done || max_cell || cut_q) begin
                    state_d = NCS_TRICKLE;
                end
            end
            NCS_SUSPEND: begin
                if (!hot && !cut_q) begin
                    state_d = NCS_TRICKLE;
                end
            end
            NCS_TRICKLE: begin
                if (max_cell) begin
                    state_d = NCS_DONE;
                end
            end
            NCS_DONE: begin
                if (!max_cell) begin
                    state_d = NCS_TRICKLE;
                end
            end
            default: state_d = NCS_QUAL;
        endcase
        if (start_now) begin
            state_d = NCS_QUAL;
        end
    end

    // Charge timer: frozen while conditioning, cleared before top-off
    always_comb begin
        timer_d = timer_q;
        if (state_q == NCS_FAST || state_q == NCS_TOPOFF) begin
            timer_d = timer_q + 40'd1;
        end
        if (state_q == NCS_FAST && state_d == NCS_TOPOFF) begin
            timer_d = '0;
        end
        if (state_q == NCS_QUAL || start_now) begin
            timer_d = 40'(TIME_RST);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cut_s1 <= 1'b0;
            cut_s2 <= 1'b0;
            cut_s3 <= 1'b0;
            cut_q <= 1'b0;
        end else begin
            cut_s1 <= below_cutoff;
            cut_s2 <= cut_s1;
            cut_s3 <= cut_s2;
            if (cut_s2 == cut_s3) begin
                cut_q <= cut_s3;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= NCS_QUAL;
            timer_q <= '0;
            start_q <= 3'b000;
            topoff_sel_q <= 1'b0;
            settle_q <= 3'(SYNC_STAGES + 1);
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            start_q <= {pwr, rep, slp};
            if (settle_q != 3'h0) begin
                settle_q <= settle_q - 3'h1;
            end
            if (state_q == NCS_QUAL) begin
                topoff_sel_q <= topoff_enable;
            end
        end
    end

    // One-second pulse frame shared by blink and trickle pulses
    always_ff @(posedge sys_clk) begin
        if (reset || start_now) begin
            sec_q <= '0;
        end else if (sec_q >= PERIOD_CYCLES - 32'd1) begin
            sec_q <= '0;
        end else begin
            sec_q <= sec_q + 32'd1;
        end
    end

    // Peak-drop sampling, fast charge only
    wire samp_due = samp_cnt_q >= sample_cyc - 40'd1;
    always_ff @(posedge sys_clk) begin
        // Next state, so no sample is started once fast charge ends
        if (reset || state_d != NCS_FAST) begin
            samp_cnt_q <= '0;
            quiet_q <= '0;
            sampling_q <= 1'b0;
        end else if (samp_due) begin
            samp_cnt_q <= '0;
            quiet_q <= 5'(QUIET_CYC);
            sampling_q <= 1'b1;
        end else begin
            samp_cnt_q <= samp_cnt_q + 40'd1;
            if (quiet_q != 5'd0) begin
                quiet_q <= quiet_q - 5'd1;
            end
            if (adc_valid) begin
                sampling_q <= 1'b0;
            end
        end
    end
    // Start conversion at end of the quiet window
    assign adc_start = sampling_q && quiet_q == 5'd1;

    // Extra bit stops a near full-scale sample from wrapping the floor
    wire [12:0] drop_floor = {1'b0, adc_sample} + {1'b0, DROP_CODES};
    always_ff @(posedge sys_clk) begin
        if (reset || state_q == NCS_QUAL) begin
            peak_q <= '0;
            have_peak_q <= 1'b0;
            drop_q <= 1'b0;
        end else if (state_q == NCS_FAST && adc_valid && sampling_q) begin
            if (!have_peak_q || adc_sample > peak_q) begin
                peak_q <= adc_sample;
            end
            have_peak_q <= 1'b1;
            // Samples during hold-off seed the peak but never flag
            if (have_peak_q && {1'b0, peak_q} >= drop_floor &&
                !in_holdoff) begin
                drop_q <= 1'b1;
            end
        end
    end
    assign peak_drop_detect = drop_q;

    // Gate and lamp drive
    logic gate_d, lamp_d;
    always_comb begin
        gate_d = 1'b0;
        lamp_d = 1'b0;
        case (state_q)
            NCS_QUAL: lamp_d = blink_phase;
            NCS_COND: begin
                gate_d = sec_q < trickle_w;
                lamp_d = blink_phase;
            end
            NCS_FAST: begin
                gate_d = quiet_q == 5'd0;
                lamp_d = 1'b1;
            end
            NCS_TOPOFF: gate_d = sec_q < TOPOFF_PULSE_CYC && !cold && !hot;
            NCS_TRICKLE: gate_d = sec_q < trickle_w;
            default: gate_d = 1'b0;
        endcase
        if (max_cell) begin
            gate_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gate_q <= 1'b0;
            lamp_on_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
            lamp_on_q <= lamp_d;
        end
    end
    assign charge_gate_output = gate_q;
    assign status_lamp_out = 1'b0;
    assign status_lamp_oe = lamp_on_q;
    assign timer_program_out = 1'b0;
    assign timer_program_oe = quiet_q != 5'd0;
    assign charge_state = state_q;

    // Checks
    sequence s_fast_twice;
        state_q == NCS_FAST ##1 state_q == NCS_FAST;
    endsequence
    sequence s_suspend_dark;
        state_q == NCS_SUSPEND ##1 !status_lamp_oe;
    endsequence
    sequence s_quiet_then_gate_low;
        timer_program_oe ##1 !charge_gate_output;
    endsequence
    sequence s_fast_to_topoff;
        state_q == NCS_FAST ##1 state_q == NCS_TOPOFF;
    endsequence

    a_fast_lamp_on: assert property (s_fast_twice |-> status_lamp_oe)
        else $error("lamp not on in fast charge");
    a_no_timer_cond: assert property (
        state_q == NCS_COND && !start_now |=> timer_q == $past(timer_q))
        else $error("timer moved while conditioning");
    a_max_blocks: assert property (max_cell |=> !charge_gate_output)
        else $error("gate on above max cell");
    a_adc_fast_only: assert property (
        adc_start |-> state_q == NCS_FAST)
        else $error("sample outside fast charge");
    a_quiet_pins: assert property (
        adc_start |-> s_quiet_then_gate_low)
        else $error("pins not quiet before sample");
    a_start_qual: assert property (start_now |=> state_q == NCS_QUAL)
        else $error("cycle not restarted");
    a_cold_cond: assert property (
        state_q == NCS_FAST && cold && !cut_q && !start_now
        |=> state_q == NCS_COND)
        else $error("cold fault not handled");
    a_cut_suspend: assert property (
        state_q == NCS_FAST && cut_q && !start_now |=> s_suspend_dark)
        else $error("cutoff not handled");
    a_holdoff_mask: assert property (
        state_q == NCS_FAST && in_holdoff && !cold && !cut_q && !timer_done
        && !start_now |=> state_q == NCS_FAST)
        else $error("fast charge ended in hold-off");
    a_hot_ignored: assert property (
        state_q == NCS_FAST && hot && !cold && !cut_q && !fast_end
        && !start_now |=> state_q == NCS_FAST)
        else $error("hot fault acted on in fast charge");
    a_topoff_clear: assert property (
        s_fast_to_topoff |-> timer_q == 40'h0)
        else $error("timer not cleared before top-off");
    a_drop_ends_fast: assert property (
        state_q == NCS_FAST && drop_q && !in_holdoff && !cut_q && !cold
        && !start_now |=> state_q inside {NCS_TOPOFF, NCS_TRICKLE})
        else $error("peak drop did not end fast charge");
endmodule

// file: inc/ncs_pkg.sv
// Package: states, timing constants and sample format for the charge sequencer
package ncs_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam real PERIOD_S = 1.0;
    localparam int PERIOD_CYC = int'(PERIOD_S * CLK_HZ);
    localparam int BLINK_HALF_CYC = PERIOD_CYC / 2;
    localparam int HOLDOFF_DIV = 32;
    localparam int SAMPLE_DIV = 128;
    localparam int QUIET_CYC = 16;
    localparam int ADC_W = 12;
    // 3.8 mV at an assumed 1 mV per code, rounded up
    localparam logic [11:0] DROP_CODES = 12'h004;
    localparam int SYNC_STAGES = 3;
    localparam logic [31:0] TIME_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        NCS_QUAL = 3'b000,
        NCS_COND = 3'b001,
        NCS_FAST = 3'b011,
        NCS_TOPOFF = 3'b010,
        NCS_TRICKLE = 3'b110,
        NCS_SUSPEND = 3'b111,
        NCS_DONE = 3'b101
    } ncs_state_t;
endpackage

// file: hdl/ncs_sync.sv
// Three-stage synchroniser with agreement check for pin inputs
module ncs_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    import ncs_pkg::*;
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end
    assign level_out = lvl_q;
endmodule

// file: test/ncs_pack_model.sv
// Pack, thermistor and converter model facing the charge sequencer
module ncs_pack_model (
    input wire logic sys_clk,
    input wire logic [1:0] temp_zone,
    input wire logic [1:0] cell_zone,
    input wire logic sag,
    input wire logic adc_start,
    output logic below_low_cell,
    output logic above_max_cell,
    output logic above_cold_fault,
    output logic below_hot_fault,
    output logic below_cutoff,
    output logic [11:0] adc_sample,
    output logic adc_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] code_q = 12'h400;
    logic busy_q = 1'b0;
    logic valid_q = 1'b0;
    // One thermistor voltage drives all three, so cutoff implies hot
    assign above_cold_fault = (temp_zone == 2'h1);
    assign below_hot_fault = temp_zone[1];
    assign below_cutoff = (temp_zone == 2'h3);
    assign below_low_cell = (cell_zone == 2'h0);
    assign above_max_cell = (cell_zone == 2'h2);
    assign adc_valid = valid_q;
    // Released bus shows the inverse so stale codes never look valid
    assign adc_sample = valid_q ? code_q : ~code_q;
    always @(posedge sys_clk) begin
        busy_q <= adc_start;
        valid_q <= busy_q;
        if (busy_q) begin
            code_q <= sag ? 12'h3f0 : 12'h400;
        end
    end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the nickel charge sequencer
`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ncs_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic power_applied = 1'b0;
    logic pack_replaced = 1'b0;
    logic sleep_exit = 1'b0;
    logic topoff_enable = 1'b0;
    logic rc_sel = 1'b0;
    logic sag = 1'b0;
    logic [1:0] temp_zone = 2'h0;
    logic [1:0] cell_zone = 2'h0;
    logic below_low_cell, above_max_cell, above_cold_fault, below_hot_fault;
    logic below_cutoff, adc_valid, adc_start, charge_gate_output;
    logic timer_program_out, timer_program_oe, status_lamp_out;
    logic status_lamp_oe, peak_drop_detect;
    logic [11:0] adc_sample;
    ncs_state_t charge_state;
    wire rc_pin = timer_program_oe ? timer_program_out : rc_sel;
    // Open-drain lamp with pull-up: low means lit
    wire lamp_pin = status_lamp_oe ? status_lamp_out : 1'b1;
    int errors = 0;
    int num_checks = 0;
    int gate_hi = 0;
    int lamp_tog = 0;
    int starts = 0;
    int stray_starts = 0;
    int noisy_starts = 0;
    logic lamp_d = 1'b1;

    ncs_pack_model i_pack (.sys_clk(sys_clk), .temp_zone(temp_zone),
        .cell_zone(cell_zone), .sag(sag), .adc_start(adc_start),
        .below_low_cell(below_low_cell), .above_max_cell(above_max_cell),
        .above_cold_fault(above_cold_fault),
        .below_hot_fault(below_hot_fault), .below_cutoff(below_cutoff),
        .adc_sample(adc_sample), .adc_valid(adc_valid));

    // Shortened counts: sample every 100 cycles, hold-off 400
    ncs_sequencer #(.MAX_TIME_CYC(40'd12800), .PULSE_SHORT_CYC(32'd10),
        .PULSE_LONG_CYC(32'd40), .TOPOFF_PULSE_CYC(32'd10),
        .PERIOD_CYCLES(32'd100)) i_dut (.sys_clk(sys_clk), .reset(reset),
        .power_applied(power_applied), .pack_replaced(pack_replaced),
        .sleep_exit(sleep_exit), .topoff_enable(topoff_enable),
        .timer_program_in(rc_pin), .below_low_cell(below_low_cell),
        .above_max_cell(above_max_cell),
        .above_cold_fault(above_cold_fault),
        .below_hot_fault(below_hot_fault), .below_cutoff(below_cutoff),
        .adc_sample(adc_sample), .adc_valid(adc_valid),
        .adc_start(adc_start), .charge_gate_output(charge_gate_output),
        .timer_program_out(timer_program_out),
        .timer_program_oe(timer_program_oe),
        .status_lamp_out(status_lamp_out), .status_lamp_oe(status_lamp_oe),
        .peak_drop_detect(peak_drop_detect), .charge_state(charge_state));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Sampled mid-cycle so the comb adc_start has settled
    always @(negedge sys_clk) begin
        gate_hi += (charge_gate_output === 1'b1);
        lamp_tog += (lamp_pin !== lamp_d);
        lamp_d = lamp_pin;
        if (adc_start === 1'b1 && reset === 1'b0) begin
            starts++;
            stray_starts += (charge_state !== NCS_FAST);
            noisy_starts += (charge_gate_output !== 1'b0 || rc_pin !== 1'b0);
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_state(input ncs_state_t s, input int lim);
        int i;
        i = 0;
        while (charge_state !== s && i < lim) begin
            step(1);
            i++;
        end
        `CHK("charge_state", s, charge_state)
    endtask

    task automatic t_qualify();
        `CHK("state_after_reset", NCS_QUAL, charge_state)
        `CHK("gate_after_reset", 1'b0, charge_gate_output)
        wait_state(NCS_COND, 20);
        power_applied = 1'b1;
        wait_state(NCS_QUAL, 20);
        wait_state(NCS_COND, 20);
    endtask

    task automatic t_condition();
        int g;
        int t;
        step(100);
        g = gate_hi;
        t = lamp_tog;
        step(200);
        `CHK("short_pulse", 20, gate_hi - g)
        `CHK("lamp_blink", 4, lamp_tog - t)
        rc_sel = 1'b1;
        step(200);
        g = gate_hi;
        step(100);
        `CHK("long_pulse", 40, gate_hi - g)
        // Good cell but cold pack: must wait, and no timer may run
        cell_zone = 2'h1;
        temp_zone = 2'h1;
        step(13000);
        `CHK("cond_no_limit", NCS_COND, charge_state)
        temp_zone = 2'h0;
        wait_state(NCS_FAST, 20);
    endtask

    task automatic t_fast();
        int g;
        step(100);
        `CHK("lamp_on_fast", 1'b0, lamp_pin)
        g = gate_hi;
        step(100);
        `CHK("fast_gate_on", 84, gate_hi - g)
        temp_zone = 2'h2;
        step(500);
        `CHK("hot_ignored", NCS_FAST, charge_state)
        temp_zone = 2'h1;
        wait_state(NCS_COND, 20);
        step(2000);
        temp_zone = 2'h0;
        wait_state(NCS_FAST, 20);
        step(11900);
        `CHK("timer_paused", NCS_FAST, charge_state)
        wait_state(NCS_TRICKLE, 400);
        step(1);
        `CHK("lamp_off_trickle", 1'b1, lamp_pin)
    endtask

    task automatic t_maintain();
        int g;
        cell_zone = 2'h2;
        wait_state(NCS_DONE, 20);
        g = gate_hi;
        step(100);
        `CHK("gate_blocked", 0, gate_hi - g)
        cell_zone = 2'h1;
        wait_state(NCS_TRICKLE, 20);
    endtask

    task automatic t_peak();
        topoff_enable = 1'b1;
        sleep_exit = 1'b1;
        wait_state(NCS_FAST, 30);
        step(150);
        sag = 1'b1;
        step(240);
        `CHK("holdoff_mask", 1'b0, peak_drop_detect)
        sag = 1'b0;
        step(160);
        sag = 1'b1;
        wait_state(NCS_TOPOFF, 300);
        `CHK("peak_flag", 1'b1, peak_drop_detect)
        sag = 1'b0;
    endtask

    task automatic t_cutoff();
        pack_replaced = 1'b1;
        wait_state(NCS_FAST, 30);
        `CHK("peak_rearmed", 1'b0, peak_drop_detect)
        temp_zone = 2'h3;
        wait_state(NCS_SUSPEND, 20);
        step(1);
        `CHK("lamp_off_suspend", 1'b1, lamp_pin)
        temp_zone = 2'h2;
        step(100);
        `CHK("suspend_hold", NCS_SUSPEND, charge_state)
        temp_zone = 2'h0;
        wait_state(NCS_TRICKLE, 20);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run is near 29000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        $display("ERROR watchdog expected done seen hang");
        final_report();
    end

    initial begin
        step(20);
        reset = 1'b0;
        step(1);
        t_qualify();
        t_condition();
        t_fast();
        t_maintain();
        t_peak();
        t_cutoff();
        `CHK("sample_outside_fast", 0, stray_starts)
        `CHK("quiet_at_sample", 0, noisy_starts)
        `CHK("samples_taken", 1'b1, starts > 0)
        final_report();
    end
endmodule
